//--- change_source_pkg.sv
// Package: register map, field layout and carrier types of the pin-change unit
package pin_pkg;

  // ----------------------------------------------------------------
  // Register word indices; the byte address is four times the index
  // ----------------------------------------------------------------
  // Printed offsets are not all multiples of four, so they are indices
  localparam logic [7:0] IDX_MASK0 = 8'h6B;
  localparam logic [7:0] IDX_MASK1 = 8'h6C;
  localparam logic [7:0] IDX_MASK2 = 8'h6D;
  localparam logic [7:0] IDX_MASK3 = 8'h6E;
  localparam logic [7:0] IDX_FLAGS = 8'h6F;
  localparam logic [7:0] IDX_CTRL = 8'h70;
  localparam logic [7:0] IDX_GIE = 8'h71;
  localparam logic [7:0] IDX_ACK = 8'h72;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h73;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h74;
  localparam logic [7:0] IDX_PINS = 8'h75;

  // ----------------------------------------------------------------
  // Widths, layout and reset values
  // ----------------------------------------------------------------
  localparam int NUM_GROUPS = 4;
  localparam int GROUP_W = 8;
  localparam int NUM_SRC = 28;
  localparam int GROUP3_W = 4;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [3:0] GRP_RESET = 4'h0;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Meta, synchronised and previous pin samples per source
  typedef struct packed {
    logic [NUM_SRC-1:0] meta;
    logic [NUM_SRC-1:0] sync;
    logic [NUM_SRC-1:0] prev;
  } sync_state_type;

  // APB answer carried together
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } apb_resp_type;

endpackage : pin_pkg

//--- change_source_change_detect.sv
// Two-flop synchroniser and logic-change detector for every source
module pin_change_detect #(
  parameter int WIDTH = pin_pkg::NUM_SRC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] pins_sync,
  output logic [WIDTH-1:0] changed
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } det_state_type;

  det_state_type s_q;
  det_state_type s_d;

  // Meta stage feeds only the sync stage; compare sync against prev
  always_comb begin
    s_d = s_q;
    s_d.meta = pins;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_sync = s_q.sync;
  assign changed = s_q.sync ^ s_q.prev;

endmodule : pin_change_detect

//--- change_source_group_flag.sv
// One sticky group flag with hardware set and two clear paths
module pin_group_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_evt,
  input wire logic sw_clear,
  input wire logic ack_clear,
  output logic flag
);

  typedef struct packed {
    logic flag;
  } flag_state_type;

  flag_state_type s_q;
  flag_state_type s_d;

  // Set beats either clear so a change in the clearing cycle is kept
  always_comb begin
    s_d = s_q;
    if (set_evt) begin
      s_d.flag = 1'b1;
    end else if (sw_clear || ack_clear) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;

endmodule : pin_group_flag

//--- change_source_unit.sv
// Pin-change interrupt flags, masks, group enables and APB register file
// Summary of operation
// - Upper four bits of flag register and group-3 mask always read zero.
// - Change on enabled source 27..24 sets group flag 3.
// - Change on enabled source 23..16 sets group flag 2.
// - Change on enabled source 15..8 sets group flag 1.
// - Change on enabled source 7..0 sets group flag 0.
// - Vector request needs group flag, global enable and group enable.
// - Group flag clears when the core starts that group's routine.
// - Writing one clears a flag; writing zero leaves it.
// - Group-3 mask bits enable their pins, gated by group 3 enable.
// - Group-2 mask at 0x6D, eight RW bits, reset zero, gated.
// - Group-1 mask at 0x6C, eight RW bits, reset zero, gated.
// - Group-0 mask at 0x6B, eight RW bits, reset zero, gated.
// - Sources with mask bit clear never set their group flag.
// - Four group enable bits sit low in the control register.
//
// Design decision made here: the APB register port.
module pin_change_interrupt_flags_masks (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pin_pkg::NUM_SRC-1:0] change_source,
  input wire logic [pin_pkg::NUM_GROUPS-1:0] vector_ack,
  output logic [pin_pkg::NUM_GROUPS-1:0] vector_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [pin_pkg::GROUP_W-1:0] mask0;
    logic [pin_pkg::GROUP_W-1:0] mask1;
    logic [pin_pkg::GROUP_W-1:0] mask2;
    logic [pin_pkg::GROUP3_W-1:0] mask3;
    logic [pin_pkg::NUM_GROUPS-1:0] ctrl;
    logic gie;
    logic [pin_pkg::NUM_GROUPS-1:0] irq_stat;
    logic [pin_pkg::NUM_GROUPS-1:0] irq_mask;
    logic [pin_pkg::NUM_GROUPS-1:0] vreq;
    logic irq;
    pin_pkg::apb_resp_type resp;
  } unit_state_type;

  unit_state_type s_q;
  unit_state_type s_d;

  logic [pin_pkg::NUM_SRC-1:0] pins_sync;
  logic [pin_pkg::NUM_SRC-1:0] changed;
  logic [pin_pkg::NUM_SRC-1:0] src_mask;
  logic [pin_pkg::NUM_GROUPS-1:0] grp_set;
  logic [pin_pkg::NUM_GROUPS-1:0] grp_swclr;
  logic [pin_pkg::NUM_GROUPS-1:0] flags;
  logic [9:0] word_idx;
  logic setup;
  logic wr_now;

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  pin_change_detect #(
    .WIDTH(pin_pkg::NUM_SRC)
  ) u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .pins(change_source),
    .pins_sync(pins_sync),
    .changed(changed)
  );

  // Flat view of all mask bits, lowest source first
  assign src_mask = {s_q.mask3, s_q.mask2, s_q.mask1, s_q.mask0};

  // APB decode; the answer comes in the access cycle after setup
  assign word_idx = paddr[11:2];
  assign setup = psel && !penable;
  assign wr_now = psel && penable && pwrite && s_q.resp.ready;

  // ----------------------------------------------------------------
  // Group flags, one per group
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < pin_pkg::NUM_GROUPS; g++) begin : g_grp
      localparam int LO = g * pin_pkg::GROUP_W;
      localparam int W = (g == pin_pkg::NUM_GROUPS - 1) ?
                         pin_pkg::GROUP3_W : pin_pkg::GROUP_W;
      // Masked-off sources never contribute; group enable gates too
      assign grp_set[g] = s_q.ctrl[g] &&
        |(changed[LO +: W] & src_mask[LO +: W]);
      assign grp_swclr[g] = wr_now &&
        (word_idx == 10'(pin_pkg::IDX_FLAGS)) && pwdata[g];
      pin_group_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(grp_set[g]),
        .sw_clear(grp_swclr[g]),
        .ack_clear(vector_ack[g]),
        .flag(flags[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Zero-wait slave: ready one cycle after setup, dropped otherwise
    s_d.resp.ready = setup;
    s_d.resp.slverr = 1'b0;
    s_d.resp.rdata = pin_pkg::RD_UNMAPPED;
    if (setup) begin
      case (paddr[11:2])
        10'(pin_pkg::IDX_MASK0): begin
          s_d.resp.rdata = {24'h000000, s_q.mask0};
        end
        10'(pin_pkg::IDX_MASK1): begin
          s_d.resp.rdata = {24'h000000, s_q.mask1};
        end
        10'(pin_pkg::IDX_MASK2): begin
          s_d.resp.rdata = {24'h000000, s_q.mask2};
        end
        10'(pin_pkg::IDX_MASK3): begin
          s_d.resp.rdata = {28'h0000000, s_q.mask3};
        end
        10'(pin_pkg::IDX_FLAGS): begin
          s_d.resp.rdata = {28'h0000000, flags};
        end
        10'(pin_pkg::IDX_CTRL): begin
          s_d.resp.rdata = {28'h0000000, s_q.ctrl};
        end
        10'(pin_pkg::IDX_GIE): begin
          s_d.resp.rdata = {31'h00000000, s_q.gie};
        end
        10'(pin_pkg::IDX_ACK): begin
          s_d.resp.rdata = pin_pkg::RD_UNMAPPED;
        end
        10'(pin_pkg::IDX_IRQ_STAT): begin
          s_d.resp.rdata = {28'h0000000, s_q.irq_stat};
        end
        10'(pin_pkg::IDX_IRQ_MASK): begin
          s_d.resp.rdata = {28'h0000000, s_q.irq_mask};
        end
        10'(pin_pkg::IDX_PINS): begin
          s_d.resp.rdata = {4'h0, pins_sync};
        end
        default: begin
          s_d.resp.slverr = 1'b1; // Unmapped: error, data zero
        end
      endcase
    end
    // Register writes take effect at the access edge
    if (wr_now) begin
      case (word_idx)
        10'(pin_pkg::IDX_MASK0): begin
          s_d.mask0 = pwdata[7:0];
        end
        10'(pin_pkg::IDX_MASK1): begin
          s_d.mask1 = pwdata[7:0];
        end
        10'(pin_pkg::IDX_MASK2): begin
          s_d.mask2 = pwdata[7:0];
        end
        10'(pin_pkg::IDX_MASK3): begin
          s_d.mask3 = pwdata[3:0];
        end
        10'(pin_pkg::IDX_CTRL): begin
          s_d.ctrl = pwdata[3:0];
        end
        10'(pin_pkg::IDX_GIE): begin
          s_d.gie = pwdata[0];
        end
        10'(pin_pkg::IDX_IRQ_MASK): begin
          s_d.irq_mask = pwdata[3:0];
        end
        default: begin
          s_d.gie = s_q.gie;
        end
      endcase
    end
    // Sticky event bits: write-one clears, a new set wins the same cycle
    if (wr_now && (word_idx == 10'(pin_pkg::IDX_IRQ_STAT))) begin
      s_d.irq_stat = s_q.irq_stat & ~pwdata[3:0];
    end
    s_d.irq_stat = s_d.irq_stat | grp_set;
    // Vector request is a level while flag, global and group enable hold
    s_d.vreq = flags & s_q.ctrl & {pin_pkg::NUM_GROUPS{s_q.gie}};
    s_d.irq = |(s_d.irq_stat & s_q.irq_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mask0 <= pin_pkg::MASK_RESET;
      s_q.mask1 <= pin_pkg::MASK_RESET;
      s_q.mask2 <= pin_pkg::MASK_RESET;
      s_q.ctrl <= pin_pkg::GRP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata = s_q.resp.rdata;
  assign pready = s_q.resp.ready;
  assign pslverr = s_q.resp.slverr;
  assign vector_req = s_q.vreq;
  assign irq = s_q.irq;

endmodule : pin_change_interrupt_flags_masks

//--- change_source_unit_checker.sv
// Port assertions of the pin-change unit
module pin_change_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [pin_pkg::NUM_SRC-1:0] change_source,
  input wire logic [pin_pkg::NUM_GROUPS-1:0] vector_ack,
  input wire logic [pin_pkg::NUM_GROUPS-1:0] vector_req
);
  // ------------------------------------------------------------
  // Sequences and assertions
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] idx;
  // Word index of the request
  assign idx = paddr[11:2];
  sequence setup_s;
    psel && !penable;
  endsequence
  // Pins quiet long enough that no set is in flight
  sequence quiet_s;
    $stable(change_source) [*5];
  endsequence
  apb_ready_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property
    (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  unmapped_err_a: assert property (setup_s ##0
    (idx < 10'h06B || idx > 10'h075) |=> pslverr)
    else $error("unmapped not refused");
  mapped_ok_a: assert property (setup_s ##0
    (idx >= 10'h06B && idx <= 10'h075) |=> !pslverr)
    else $error("mapped refused");
  upper_zero_a: assert property (setup_s ##0 (!pwrite &&
    (idx == 10'h06E || idx == 10'h06F)) |=> prdata[31:4] == 28'h0)
    else $error("upper bits not zero");
  ack_clear_a: assert property
    (quiet_s ##0 vector_ack[0] |=> ##1 !vector_req[0])
    else $error("request kept after ack");
endmodule : pin_change_checker

bind pin_change_interrupt_flags_masks pin_change_checker pin_change_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .change_source(change_source),
  .vector_ack(vector_ack), .vector_req(vector_req));

//--- change_source_core_model.sv
// Core model that starts routines for requesting groups
module pin_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] vector_req,
  input wire logic en,
  input wire logic [3:0] dly,
  output logic [3:0] vector_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Acknowledge after dly idle cycles
  // ------------------------------------------------------------
  logic [3:0] cnt_q;
  // Lowest group first; dly of 1 or more avoids a second start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      vector_ack <= 4'h0;
    end else begin
      vector_ack <= 4'h0;
      if (en && |vector_req && vector_ack == 4'h0) begin
        if (cnt_q == dly) begin
          vector_ack <= vector_req & (~vector_req + 4'h1);
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else begin
        cnt_q <= 4'h0;
      end
    end
  end
endmodule : pin_core_model

//--- change_source_unit_tb_top.sv
// Self-checking bench of the pin-change unit
module pin_change_interrupt_flags_masks_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Signals, instances and tasks
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] idx;
    logic [31:0] wd;
    logic [31:0] ex;
  } row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [27:0] change_source = 28'h0;
  logic [3:0] vector_ack;
  logic [3:0] vector_req;
  logic irq;
  logic core_en = 1'b0;
  logic rd_err;
  int err_total = 0;
  int comparisons = 0;
  row_type rows [7] = '{'{8'h6B, 32'hFF, 32'hFF},
    '{8'h6C, 32'hA5, 32'hA5}, '{8'h6D, 32'h5A, 32'h5A},
    '{8'h6E, 32'hFF, 32'h0F}, '{8'h70, 32'hFF, 32'h0F},
    '{8'h6F, 32'hF0, 32'h0}, '{8'h72, 32'hFF, 32'h0}};
  // Half period of the 50 ns clock
  always #25 pclk = ~pclk;
  pin_change_interrupt_flags_masks pin_change_interrupt_flags_masks_i (
    .pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .change_source(change_source),
    .vector_ack(vector_ack), .vector_req(vector_req), .irq(irq));
  pin_core_model pin_core_model_i (.pclk(pclk),
    .presetn(presetn), .vector_req(vector_req), .en(core_en),
    .dly(4'h3), .vector_ack(vector_ack));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Idle edge first, so psel never changes twice in one step
  task automatic apb(input logic [7:0] idx, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    apb(idx, 1'b1, wd, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] ex);
    logic [31:0] d;
    apb(idx, 1'b0, 32'h0, d);
    chk(d, ex);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic test_done;
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // Watchdog far beyond the few hundred cycles of the run
  initial begin
    #2000000;
    err_total++;
    test_done();
  end
  // Main sequence: reset values, rows, then awkward cases
  initial begin
    tick(12);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h6B + i), 32'h0);
    end
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx, rows[i].ex);
    end
    rd(8'h10, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    for (int g = 0; g < 4; g++) begin
      wr(8'(8'h6B + g), 32'h2);
      wr(8'h70, 32'h1 << g);
      change_source[8*g+1] <= ~change_source[8*g+1];
      tick(6);
      rd(8'h6F, 32'h1 << g);
      wr(8'h6F, 32'h0);
      rd(8'h6F, 32'h1 << g);
      wr(8'h6F, 32'h1 << g);
      rd(8'h6F, 32'h0);
      wr(8'(8'h6B + g), 32'h0);
    end
    change_source <= ~change_source;
    tick(6);
    rd(8'h6F, 32'h0);
    wr(8'h6B, 32'hFF);
    wr(8'h70, 32'h0);
    change_source[0] <= ~change_source[0];
    tick(6);
    rd(8'h6F, 32'h0);
    wr(8'h70, 32'h1);
    change_source[3] <= ~change_source[3];
    tick(6);
    rd(8'h6F, 32'h1);
    chk({31'h0, vector_req[0]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Every group has had one event by now, so all status bits stand
    rd(8'h73, 32'hF);
    wr(8'h74, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wr(8'h73, 32'hF);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rd(8'h73, 32'h0);
    rd(8'h74, 32'h1);
    core_en <= 1'b1;
    wr(8'h71, 32'h1);
    for (int n = 0; n < 20 && vector_req[0] !== 1'b1; n++) tick(1);
    chk({31'h0, vector_req[0]}, 32'h1);
    tick(8);
    rd(8'h6F, 32'h0);
    rd(8'h71, 32'h1);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    rd(8'h6B, 32'h0);
    rd(8'h70, 32'h0);
    rd(8'h71, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Pins have been still for many cycles, so the synchronised view agrees
    rd(8'h75, {4'h0, change_source});
    test_done();
  end
endmodule : pin_change_interrupt_flags_masks_tb_top
